// ---- pkg/chan_ctl_pkg.sv ----
// Constants for the per-channel sync, tuning and input control block.
// Assumes a byte-wide channel address space reached from the micro port.
package chan_ctl_pkg;
    localparam logic [7:0] ADDR_COEF_LAST   = 8'h7F;
    localparam logic [7:0] ADDR_SLEEP       = 8'h80;
    localparam logic [7:0] ADDR_SOFT_SYNC   = 8'h81;
    localparam logic [7:0] ADDR_PIN_SYNC    = 8'h82;
    localparam logic [7:0] ADDR_START_HOLD  = 8'h83;
    localparam logic [7:0] ADDR_FREQ_HOLD   = 8'h84;
    localparam logic [7:0] ADDR_FREQ_LOW    = 8'h85;
    localparam logic [7:0] ADDR_FREQ_HIGH   = 8'h86;
    localparam logic [7:0] ADDR_PHASE_OFS   = 8'h87;
    localparam logic [7:0] ADDR_TUNE_CTRL   = 8'h88;
    localparam logic [7:0] ADDR_RS_DEC      = 8'h90;
    localparam logic [7:0] ADDR_RS_INTERP   = 8'h91;
    localparam logic [7:0] ADDR_RS_SCALE    = 8'h92;
    localparam logic [7:0] ADDR_FIR_CTRL    = 8'hA4;
    // Tuning control fields
    localparam int CTRL_BYPASS      = 0;
    localparam int CTRL_PH_DITHER   = 1;
    localparam int CTRL_AMP_DITHER  = 2;
    localparam int CTRL_CLR_PHASE   = 3;
    localparam int CTRL_EN_MODE_LO  = 4;
    localparam int CTRL_PORT_SEL    = 6;
    localparam int CTRL_SYNC_SEL_LO = 7;
    // Sync register fields and FIR control bank bit
    localparam int SYNC_START_BIT   = 0;
    localparam int SYNC_HOP_BIT     = 1;
    localparam int FIR_BANK_BIT     = 8;
    // Enable modes
    localparam logic [1:0] EN_MASK_LOW  = 2'h0;
    localparam logic [1:0] EN_ON_HIGH   = 2'h1;
    localparam logic [1:0] EN_RISE      = 2'h2;
    localparam logic [1:0] EN_FALL      = 2'h3;
    // Reset values and hold-off compare constants
    localparam logic        SLEEP_RESET = 1'h1;
    localparam logic [15:0] HOLD_RESET  = 16'h0000;
    localparam logic [8:0]  CTRL_RESET  = 9'h000;
    localparam logic [15:0] HOLD_ONE    = 16'h0001;
    localparam logic [15:0] HOLD_ZERO   = 16'h0000;
endpackage

// ---- hw/coef_ram.sv ----
// Coefficient store: two banks of words, registered read.
// Assumes one access per clock from the register port.
`timescale 1ns/1ps
module coef_ram #(
    parameter int WIDTH = 20,
    parameter int ABITS = 8
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [ABITS-1:0] addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:(1<<ABITS)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ---- hw/holdoff_counter.sv ----
// Hold-off down counter: fires when it reaches one after a sync.
// Assumes sync is a one-cycle pulse; a load value of zero suppresses it.
`timescale 1ns/1ps
module holdoff_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             sync,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  fire
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    wire              fire_now = (sync && load_value == WIDTH'(1))
                               || (!sync && count_reg == WIDTH'(2));

    // A value of one fires on the sync itself, zero never loads
    always_comb begin
        count_next = count_reg;
        if (sync) begin
            count_next = (load_value > WIDTH'(1)) ? load_value : '0;
        end else if (count_reg > WIDTH'(1)) begin
            count_next = count_reg - WIDTH'(1);
        end
        if (count_next == WIDTH'(1)) begin
            count_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= '0;
            fire      <= 1'b0;
        end else begin
            count_reg <= count_next;
            fire      <= fire_now;
        end
    end
endmodule

// ---- hw/chan_sync_tuner.sv ----
// Per-channel sync, tuning frequency, input select and sample qualify logic.
// Assumes a synchronous byte-addressed micro port and a synchronous converter.
//
// Overview of operation
// - Sleep bit high holds channel in low power; low lets samples through.
// - Global sleep access at external address 3 writes all channel sleep bits.
// - Soft hop loads frequency hold-off; at one, active frequency loads.
// - Soft start loads start hold-off; at one, sleep clears, channel starts.
// - Pin sync enables let selected pin pulse act like soft sync.
// - Control bits 8-7 pick one of four sync pins.
// - Start while running realigns filter phase instead of restarting.
// - Start hold-off one starts at once; zero suppresses start.
// - Frequency hold-off one hops at once; zero suppresses hop.
// - Control bit 3 clears phase accumulator on hop; else phase continuous.
// - Two shadowed halves move to active word on wake or hop.
// - Frequency hold-off of one makes shadow writes take effect at once.
// - Sixteen-bit phase offset added as fraction of full cycle.
// - Control bit 6 picks port A or B mantissa, exponent, qualifier.
// - Mode 00 samples every clock, zeroing data when qualifier low.
// - Mode 01 accepts samples only when qualifier high.
// - Mode 10 takes the sample after qualifier rises.
// - Mode 11 takes the sample after qualifier falls.
// - Control bits 2 and 1 enable amplitude and phase dither.
// - Bypass bit sends port A to I path, port B to Q path.
// - Coefficient RAM is 128 by 20 words, second bank by control bit.
`timescale 1ns/1ps
module chan_sync_tuner #(
    parameter int MANT_W  = 14,
    parameter int EXP_W   = 3,
    parameter int COEF_W  = 20,
    parameter int FREQ_W  = 32,
    parameter int PHASE_W = 16
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         addr,
    input  wire logic [19:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    input  wire logic               global_sleep_wr,
    input  wire logic               global_sleep_bit,
    output logic      [19:0]        rdata,
    input  wire logic [3:0]         sync_pins,
    input  wire logic [MANT_W-1:0]  input_mantissa_a,
    input  wire logic [EXP_W-1:0]   input_exponent_a,
    input  wire logic               sample_qualifier_a,
    input  wire logic [MANT_W-1:0]  input_mantissa_b,
    input  wire logic [EXP_W-1:0]   input_exponent_b,
    input  wire logic               sample_qualifier_b,
    output logic                    channel_sleep,
    output logic                    sample_valid,
    output logic      [MANT_W-1:0]  sample_mantissa,
    output logic      [EXP_W-1:0]   sample_exponent,
    output logic      [MANT_W-1:0]  bypass_i,
    output logic      [MANT_W-1:0]  bypass_q,
    output logic                    bypass_active,
    output logic      [PHASE_W-1:0] tuning_phase,
    output logic                    amp_dither_en,
    output logic                    phase_dither_en,
    output logic                    filter_realign
);
    // Registers
    logic                sleep_reg;
    logic [2:0]          pin_sync_reg;
    logic [15:0]         start_hold_reg;
    logic [15:0]         freq_hold_reg;
    logic [15:0]         freq_low_reg;
    logic [15:0]         freq_high_reg;
    logic [15:0]         phase_ofs_reg;
    logic [8:0]          ctrl_reg;
    logic [11:0]         rs_dec_reg;
    logic [8:0]          rs_interp_reg;
    logic [11:0]         rs_scale_reg;
    logic [10:0]         fir_ctrl_reg;
    logic [FREQ_W-1:0]   active_freq_reg;
    logic [FREQ_W-1:0]   phase_acc_reg;
    logic                qual_prev_reg;
    logic                rd_coef_reg;
    logic [19:0]         rdata_reg;
    logic                sleep_next;

    // Decodes
    wire wr_coef   = wr && (addr <= chan_ctl_pkg::ADDR_COEF_LAST);
    wire wr_sleep  = wr && (addr == chan_ctl_pkg::ADDR_SLEEP);
    wire wr_soft   = wr && (addr == chan_ctl_pkg::ADDR_SOFT_SYNC);
    wire wr_pin    = wr && (addr == chan_ctl_pkg::ADDR_PIN_SYNC);
    wire wr_shold  = wr && (addr == chan_ctl_pkg::ADDR_START_HOLD);
    wire wr_fhold  = wr && (addr == chan_ctl_pkg::ADDR_FREQ_HOLD);
    wire wr_flow   = wr && (addr == chan_ctl_pkg::ADDR_FREQ_LOW);
    wire wr_fhigh  = wr && (addr == chan_ctl_pkg::ADDR_FREQ_HIGH);
    wire wr_phase  = wr && (addr == chan_ctl_pkg::ADDR_PHASE_OFS);
    wire wr_ctrl   = wr && (addr == chan_ctl_pkg::ADDR_TUNE_CTRL);
    wire wr_rsdec  = wr && (addr == chan_ctl_pkg::ADDR_RS_DEC);
    wire wr_rsint  = wr && (addr == chan_ctl_pkg::ADDR_RS_INTERP);
    wire wr_rsscl  = wr && (addr == chan_ctl_pkg::ADDR_RS_SCALE);
    wire wr_fir    = wr && (addr == chan_ctl_pkg::ADDR_FIR_CTRL);

    // Sync sources
    wire [1:0] sync_sel   = ctrl_reg[chan_ctl_pkg::CTRL_SYNC_SEL_LO +: 2];
    wire       pin_pulse  = sync_pins[sync_sel];
    wire       soft_start = wr_soft && wdata[chan_ctl_pkg::SYNC_START_BIT];
    wire       soft_hop   = wr_soft && wdata[chan_ctl_pkg::SYNC_HOP_BIT];
    wire       pin_start  = pin_pulse && pin_sync_reg[chan_ctl_pkg::SYNC_START_BIT];
    wire       pin_hop    = pin_pulse && pin_sync_reg[chan_ctl_pkg::SYNC_HOP_BIT];
    wire       start_sync = soft_start || pin_start;
    wire       hop_sync   = soft_hop || pin_hop;
    wire       start_fire;
    wire       hop_fire;

    holdoff_counter #(.WIDTH(16)) start_cnt (
        .clk        (clk),
        .reset_n    (reset_n),
        .sync       (start_sync),
        .load_value (start_hold_reg),
        .fire       (start_fire)
    );

    holdoff_counter #(.WIDTH(16)) hop_cnt (
        .clk        (clk),
        .reset_n    (reset_n),
        .sync       (hop_sync),
        .load_value (freq_hold_reg),
        .fire       (hop_fire)
    );

    // Coefficient RAM, bank bit forms the top address bit
    wire [7:0]        coef_addr = {fir_ctrl_reg[chan_ctl_pkg::FIR_BANK_BIT], addr[6:0]};
    wire [COEF_W-1:0] coef_rdata;

    coef_ram #(.WIDTH(COEF_W), .ABITS(8)) coef_mem (
        .clk   (clk),
        .we    (wr_coef),
        .addr  (coef_addr),
        .wdata (wdata[COEF_W-1:0]),
        .rdata (coef_rdata)
    );

    // Sleep: start wins over a software write in the same cycle
    wire waking = sleep_reg && !sleep_next;
    always_comb begin
        sleep_next = sleep_reg;
        if (global_sleep_wr) begin
            sleep_next = global_sleep_bit;
        end
        if (wr_sleep) begin
            sleep_next = wdata[0];
        end
        if (start_fire) begin
            sleep_next = 1'b0;
        end
    end

    // Active frequency transfer: on wake, on hop, or direct when hold-off is one
    wire direct_upd = (wr_flow || wr_fhigh) && (freq_hold_reg == chan_ctl_pkg::HOLD_ONE);
    wire [15:0] low_src  = wr_flow ? wdata[15:0] : freq_low_reg;
    wire [15:0] high_src = wr_fhigh ? wdata[15:0] : freq_high_reg;
    wire load_active = waking || hop_fire || direct_upd;
    wire clr_acc     = hop_fire && ctrl_reg[chan_ctl_pkg::CTRL_CLR_PHASE];

    // Input port selection and qualification
    wire             port_b    = ctrl_reg[chan_ctl_pkg::CTRL_PORT_SEL];
    wire [MANT_W-1:0] sel_mant = port_b ? input_mantissa_b : input_mantissa_a;
    wire [EXP_W-1:0]  sel_exp  = port_b ? input_exponent_b : input_exponent_a;
    wire              sel_qual = port_b ? sample_qualifier_b : sample_qualifier_a;
    wire [1:0]        en_mode  = ctrl_reg[chan_ctl_pkg::CTRL_EN_MODE_LO +: 2];
    logic             take;
    logic             zero_data;

    always_comb begin
        take      = 1'b0;
        zero_data = 1'b0;
        case (en_mode)
            chan_ctl_pkg::EN_MASK_LOW: begin
                take      = 1'b1;
                zero_data = !sel_qual;
            end
            chan_ctl_pkg::EN_ON_HIGH: take = sel_qual;
            chan_ctl_pkg::EN_RISE:    take = sel_qual && !qual_prev_reg;
            chan_ctl_pkg::EN_FALL:    take = !sel_qual && qual_prev_reg;
            default:                  take = 1'b0;
        endcase
    end

    wire run = !sleep_reg;

    // Register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sleep_reg      <= chan_ctl_pkg::SLEEP_RESET;
            pin_sync_reg   <= 3'h0;
            start_hold_reg <= chan_ctl_pkg::HOLD_RESET;
            freq_hold_reg  <= chan_ctl_pkg::HOLD_RESET;
            freq_low_reg   <= 16'h0000;
            freq_high_reg  <= 16'h0000;
            phase_ofs_reg  <= 16'h0000;
            ctrl_reg       <= chan_ctl_pkg::CTRL_RESET;
            rs_dec_reg     <= 12'h000;
            rs_interp_reg  <= 9'h000;
            rs_scale_reg   <= 12'h000;
            fir_ctrl_reg   <= 11'h000;
        end else begin
            sleep_reg <= sleep_next;
            if (wr_pin)   pin_sync_reg   <= wdata[2:0];
            if (wr_shold) start_hold_reg <= wdata[15:0];
            if (wr_fhold) freq_hold_reg  <= wdata[15:0];
            if (wr_flow)  freq_low_reg   <= wdata[15:0];
            if (wr_fhigh) freq_high_reg  <= wdata[15:0];
            if (wr_phase) phase_ofs_reg  <= wdata[15:0];
            if (wr_ctrl)  ctrl_reg       <= wdata[8:0];
            if (wr_rsdec) rs_dec_reg     <= wdata[11:0];
            if (wr_rsint) rs_interp_reg  <= wdata[8:0];
            if (wr_rsscl) rs_scale_reg   <= wdata[11:0];
            if (wr_fir)   fir_ctrl_reg   <= wdata[10:0];
        end
    end

    // Tuning oscillator phase; accumulator advances per accepted sample
    wire [FREQ_W-1:0] acc_base = clr_acc ? '0 : phase_acc_reg;
    wire [FREQ_W-1:0] freq_use = load_active ? {high_src, low_src} : active_freq_reg;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active_freq_reg <= '0;
            phase_acc_reg   <= '0;
        end else begin
            if (load_active) begin
                active_freq_reg <= {high_src, low_src};
            end
            if (clr_acc) begin
                phase_acc_reg <= run && take ? freq_use : '0;
            end else if (run && take) begin
                phase_acc_reg <= acc_base + freq_use;
            end
        end
    end

    // Sample path and outputs, all registered
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            qual_prev_reg   <= 1'b0;
            channel_sleep   <= chan_ctl_pkg::SLEEP_RESET;
            sample_valid    <= 1'b0;
            sample_mantissa <= '0;
            sample_exponent <= '0;
            bypass_i        <= '0;
            bypass_q        <= '0;
            bypass_active   <= 1'b0;
            tuning_phase    <= '0;
            amp_dither_en   <= 1'b0;
            phase_dither_en <= 1'b0;
            filter_realign  <= 1'b0;
        end else begin
            qual_prev_reg   <= sel_qual;
            channel_sleep   <= sleep_next;
            sample_valid    <= run && take;
            // Masked or sleeping inputs read as zero so downstream stays quiet
            sample_mantissa <= (run && take && !zero_data) ? sel_mant : '0;
            sample_exponent <= (run && take && !zero_data) ? sel_exp : '0;
            bypass_i        <= run ? input_mantissa_a : '0;
            bypass_q        <= run ? input_mantissa_b : '0;
            bypass_active   <= ctrl_reg[chan_ctl_pkg::CTRL_BYPASS];
            // Offset wraps modulo a full cycle
            tuning_phase    <= phase_acc_reg[FREQ_W-1 -: PHASE_W] + phase_ofs_reg;
            amp_dither_en   <= ctrl_reg[chan_ctl_pkg::CTRL_AMP_DITHER];
            phase_dither_en <= ctrl_reg[chan_ctl_pkg::CTRL_PH_DITHER];
            filter_realign  <= start_fire && !sleep_reg;
        end
    end

    // Read back; coefficient reads arrive one cycle later from the RAM register
    logic [19:0] rd_mux;
    always_comb begin
        case (addr)
            chan_ctl_pkg::ADDR_SLEEP:      rd_mux = {19'h00000, sleep_reg};
            chan_ctl_pkg::ADDR_PIN_SYNC:   rd_mux = {17'h00000, pin_sync_reg};
            chan_ctl_pkg::ADDR_START_HOLD: rd_mux = {4'h0, start_hold_reg};
            chan_ctl_pkg::ADDR_FREQ_HOLD:  rd_mux = {4'h0, freq_hold_reg};
            chan_ctl_pkg::ADDR_FREQ_LOW:   rd_mux = {4'h0, freq_low_reg};
            chan_ctl_pkg::ADDR_FREQ_HIGH:  rd_mux = {4'h0, freq_high_reg};
            chan_ctl_pkg::ADDR_PHASE_OFS:  rd_mux = {4'h0, phase_ofs_reg};
            chan_ctl_pkg::ADDR_TUNE_CTRL:  rd_mux = {11'h000, ctrl_reg};
            chan_ctl_pkg::ADDR_RS_DEC:     rd_mux = {8'h00, rs_dec_reg};
            chan_ctl_pkg::ADDR_RS_INTERP:  rd_mux = {11'h000, rs_interp_reg};
            chan_ctl_pkg::ADDR_RS_SCALE:   rd_mux = {8'h00, rs_scale_reg};
            chan_ctl_pkg::ADDR_FIR_CTRL:   rd_mux = {9'h000, fir_ctrl_reg};
            default:                       rd_mux = 20'h00000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_coef_reg <= 1'b0;
            rdata_reg   <= 20'h00000;
        end else begin
            rd_coef_reg <= rd && (addr <= chan_ctl_pkg::ADDR_COEF_LAST);
            rdata_reg   <= rd ? rd_mux : 20'h00000;
        end
    end

    assign rdata = rd_coef_reg ? coef_rdata : rdata_reg;

    // Checks
    sleep_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        start_fire |=> !sleep_reg)
        else $error("start did not wake channel");
    hop_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (hop_sync && freq_hold_reg == 16'h0000 && !hop_fire) |=> !hop_fire)
        else $error("hop with zero hold-off fired");
    hop_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        hop_fire |=> active_freq_reg == $past({high_src, low_src}))
        else $error("active frequency not loaded on hop");
    direct_upd_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_flow && freq_hold_reg == 16'h0001) |=> active_freq_reg[15:0] == $past(wdata[15:0]))
        else $error("direct frequency update missed");
    shadow_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !load_active |=> $stable(active_freq_reg))
        else $error("active frequency changed without cause");
    mask_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (en_mode == 2'h0 && !sel_qual) |=> sample_mantissa == '0)
        else $error("masked sample not zero");
    rise_take_a: assert property (@(posedge clk) disable iff (!reset_n)
        (run && en_mode == 2'h2 && sel_qual && !qual_prev_reg) |=> sample_valid)
        else $error("rising qualifier sample missed");
    sleep_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        sleep_reg |=> !sample_valid)
        else $error("sample passed while asleep");
    global_sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (global_sleep_wr && !wr_sleep && !start_fire) |=> sleep_reg == $past(global_sleep_bit))
        else $error("global sleep not applied");
endmodule

// ---- verif/adc_model.sv ----
// Converter model: ports A and B, each with mantissa, exponent and qualifier.
// Assumes the sample clock is clk; data moves just after each falling edge.
`timescale 1ns/1ps
module adc_model (
    input  wire logic        clk,
    output logic      [13:0] mant_a,
    output logic      [2:0]  exp_a,
    output logic             qual_a,
    output logic      [13:0] mant_b,
    output logic      [2:0]  exp_b,
    output logic             qual_b
);
    logic [15:0] cnt = 16'h0001;
    // New word every cycle, so a stale capture never matches by chance
    always @(negedge clk) begin
        cnt <= {cnt[14:0], cnt[15] ^ cnt[13] ^ cnt[12] ^ cnt[10]};
    end
    assign mant_a = cnt[13:0];
    assign exp_a  = cnt[2:0];
    // Qualifiers run in irregular bursts: fast and slow toggling both occur
    assign qual_a = cnt[15];
    assign mant_b = ~cnt[15:2];
    assign exp_b  = cnt[5:3];
    assign qual_b = cnt[14] ^ cnt[3];
endmodule

// ---- verif/chan_sync_tuner_tb_top.sv ----
// Bench for the channel sync and tuning block, with a converter model.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module chan_sync_tuner_tb_top;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [19:0] wdata = 20'h00000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        gs_wr = 1'b0;
    logic        gs_bit = 1'b0;
    logic [3:0]  sp = 4'h0;
    logic [19:0] rdata;
    logic [13:0] ma, mb, smant, bi, bq, ma_d, mb_d;
    logic [2:0]  ea, eb, sexp;
    logic        qa, qb, sleep, sv, byp, ampd, phd, realign, q, tk;
    logic [15:0] phase, ph, p0;
    logic [31:0] seed = 32'h00007093;
    logic [19:0] rq[$];
    logic [16:0] sq[$];
    logic        rd_d = 1'b0;
    logic        pred = 1'b0;
    logic        pred_d = 1'b0;
    logic        q_prev = 1'b0;
    logic [8:0]  ctrl = 9'h000;
    int          mismatches = 0;
    int          checks_done = 0;

    always #25 clk = ~clk;

    adc_model i_adc (.clk(clk), .mant_a(ma), .exp_a(ea), .qual_a(qa),
        .mant_b(mb), .exp_b(eb), .qual_b(qb));

    chan_sync_tuner i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .global_sleep_wr(gs_wr), .global_sleep_bit(gs_bit),
        .rdata(rdata), .sync_pins(sp), .input_mantissa_a(ma), .input_exponent_a(ea),
        .sample_qualifier_a(qa), .input_mantissa_b(mb), .input_exponent_b(eb),
        .sample_qualifier_b(qb), .channel_sleep(sleep), .sample_valid(sv),
        .sample_mantissa(smant), .sample_exponent(sexp), .bypass_i(bi), .bypass_q(bq),
        .bypass_active(byp), .tuning_phase(phase), .amp_dither_en(ampd),
        .phase_dither_en(phd), .filter_realign(realign));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [19:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [19:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        rq.push_back(e);
        @(negedge clk);
        rd = 1'b0;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic run_samples(input logic [8:0] c);
        ctrl = c;
        wr_reg(8'h88, {11'h000, c});
        wait_n(3);
        pred = 1'b1;
        wait_n(40);
        pred = 1'b0;
        wait_n(3);
        check("sample_leftover", 0, sq.size());
        sq.delete();
    endtask

    task automatic step(input logic [15:0] e);
        @(negedge clk);
        p0 = phase;
        @(negedge clk);
        check("phase_step", e, 16'(phase - p0));
    endtask

    task automatic stop_test();
        $display("checks_done %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Results are compared one edge after they were predicted
    assign q = ctrl[6] ? qb : qa;
    assign tk = ctrl[5:4] == 2'h0 || (ctrl[5:4] == 2'h1 && q) ||
        (ctrl[5:4] == 2'h2 && q && !q_prev) || (ctrl[5:4] == 2'h3 && !q && q_prev);
    always @(posedge clk) begin
        if (rd_d) begin
            check("rdata", rq.pop_front(), rdata);
        end
        if (pred_d) begin
            check("bypass", {ma_d, mb_d}, {bi, bq});
            if (sv && sq.size() == 0) begin
                check("sample_extra", 0, 1);
            end else if (sv) begin
                check("sample", sq.pop_front(), {sexp, smant});
            end
        end
        if (pred && tk) begin
            sq.push_back((ctrl[5:4] == 2'h0 && !q) ? 17'h00000 :
                ctrl[6] ? {eb, mb} : {ea, ma});
        end
        rd_d <= rd;
        pred_d <= pred;
        q_prev <= q;
        ma_d <= ma;
        mb_d <= mb;
    end

    initial begin
        #500000;
        mismatches++;
        stop_test();
    end

    initial begin
        logic [7:0]  ra[7];
        logic [19:0] rm[7];
        ra = '{8'h83, 8'h87, 8'h90, 8'h91, 8'h92, 8'h81, 8'h89};
        rm = '{20'hFFFF, 20'hFFFF, 20'hFFF, 20'h1FF, 20'hFFF, 20'h0, 20'h0};
        wait_n(12);
        reset_n = 1'b1;
        check("sleep_reset", 1, sleep);
        rd_reg(8'h88, 20'h0);
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            if (ra[i] == 8'h87) ph = seed[15:0];
            // A sync write stays zero so no stray start or hop is armed
            wr_reg(ra[i], (ra[i] == 8'h81) ? 20'h00000 : seed[19:0]);
            rd_reg(ra[i], seed[19:0] & rm[i]);
        end
        check("phase_offset", ph, phase);
        wr_reg(8'h88, 20'h007);
        wait_n(2);
        check("ctrl_out", 3'h7, {ampd, phd, byp});
        wr_reg(8'h88, 20'h002);
        wait_n(2);
        check("ctrl_out", 3'h2, {ampd, phd, byp});
        wr_reg(8'h05, 20'hA5C3E);
        wr_reg(8'hA4, 20'h100);
        wr_reg(8'h05, 20'h3B1D7);
        rd_reg(8'h05, 20'h3B1D7);
        wr_reg(8'hA4, 20'h000);
        rd_reg(8'h05, 20'hA5C3E);
        $display("done: registers");
        wr_reg(8'h83, 20'h0);
        wr_reg(8'h81, 20'h1);
        wait_n(10);
        check("sleep_hold0", 1, sleep);
        wr_reg(8'h83, 20'h3);
        wr_reg(8'h81, 20'h1);
        wait_n(2);
        check("sleep_early", 1, sleep);
        wait_n(3);
        check("sleep_woke", 0, sleep);
        check("phase_wake", ph, phase);
        wr_reg(8'h83, 20'h1);
        wr_reg(8'h81, 20'h1);
        p0 = 16'h0;
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            if (realign === 1'b1) p0 = 16'h1;
        end
        check("realign", 1, p0);
        $display("done: start");
        for (int m = 0; m < 8; m++) begin
            run_samples({2'h0, m[2], m[1:0], 4'h0});
        end
        $display("done: samples");
        // Mode 00 so the accumulator advances on every clock
        wr_reg(8'h88, 20'h000);
        wr_reg(8'h84, 20'h2);
        wr_reg(8'h86, 20'h1);
        wr_reg(8'h85, 20'h0);
        step(16'h0);
        wr_reg(8'h81, 20'h2);
        wait_n(4);
        step(16'h1);
        wr_reg(8'h84, 20'h0);
        wr_reg(8'h86, 20'h2);
        wr_reg(8'h81, 20'h2);
        wait_n(4);
        step(16'h1);
        wr_reg(8'h84, 20'h1);
        wr_reg(8'h86, 20'h3);
        wait_n(2);
        step(16'h3);
        wr_reg(8'h88, 20'h008);
        wr_reg(8'h81, 20'h2);
        wait_n(2);
        check("phase_clear", 16'(ph + 16'h0003), phase);
        $display("done: hop");
        @(negedge clk);
        gs_wr = 1'b1;
        gs_bit = 1'b1;
        @(negedge clk);
        gs_wr = 1'b0;
        check("global_sleep", 1, sleep);
        wr_reg(8'h80, 20'h0);
        check("local_wake", 0, sleep);
        wr_reg(8'h80, 20'h1);
        wr_reg(8'h82, 20'h1);
        wr_reg(8'h88, 20'h100);
        sp = 4'h2;
        @(negedge clk);
        sp = 4'h0;
        wait_n(3);
        check("pin_other", 1, sleep);
        sp = 4'h4;
        @(negedge clk);
        sp = 4'h0;
        wait_n(3);
        check("pin_start", 0, sleep);
        $display("done: sleep and pins");
        stop_test();
    end
endmodule
